/* File: design/mframe_sync_ctrl.sv */
// Multiframe/superframe sync controller with APB register access
//
// Notes on behaviour
// - Counter advances per frame, wraps 0..39
// - Detected sync event resets the counter
// - Detection off: counter runs free, outputs continue
// - Resets only when detect enable is one
// - Source: frame pulse, pin, data, internal
// - Sample at delay plus one bit clocks
// - Event only when sample differs from last
// - Window reopens at 39 or 7
// - Resync needs all four conditions together
// - Slave frame aligned at first falling edge only
// - Normal pulse one or two bit clocks
// - Marker frames extend trailing edge one bit clock
// - Marker every 40th or 8th frame
// - Long bit gives early leading edge
// - Long plus marking combine both effects
// - Line sync only enabled and NT mode
// - Line sync driven only when enabled
// - Line sync offset minus four to three
`timescale 1ns/10ps
module mframe_sync_ctrl
  import mframe_sync_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // PCM bus pins
  input  wire logic                 bit_clock_io,
  input  wire logic                 frame_pulse_in,
  output logic                      frame_pulse_out,
  output logic                      frame_pulse_oe,
  input  wire logic                 pcm_data_line_one,
  // Sync sources
  input  wire logic                 sync_in_pin,
  input  wire logic                 internal_mframe_sync_in,
  // Line interface sync
  output logic      [NUM_LINES-1:0] line_mframe_sync_out
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [C0_WIDTH-1:0] mframe_sync_config0;
  logic [C1_WIDTH-1:0] mframe_sync_config1;
  logic [PM_WIDTH-1:0] pcm_mode_config0;

  logic                 sync_detect_enable;
  sync_src_t            sync_source_select;
  logic                 resync_guard_select;
  logic                 frame_pulse_mark_enable;
  logic                 mark_repeat_select;
  logic [NUM_LINES-1:0] line_sync_out_enable;
  logic                 line_repeat_select;
  logic signed [2:0]    line_offset;
  logic [NUM_LINES-1:0] line_nt_mode;
  logic [3:0]           sync_sample_delay;
  logic                 frame_pulse_long;
  logic                 master_mode;
  logic [POS_W-1:0]     frame_len;

  assign sync_detect_enable      = mframe_sync_config0[C0_DETECT_EN];
  assign sync_source_select      = sync_src_t'(mframe_sync_config0[C0_SRC_LO +: 2]);
  assign resync_guard_select     = mframe_sync_config0[C0_GUARD];
  assign frame_pulse_mark_enable = mframe_sync_config0[C0_MARK_EN];
  assign mark_repeat_select      = mframe_sync_config0[C0_MARK_REP];
  assign line_sync_out_enable    = mframe_sync_config0[C0_LINE_EN_LO +: NUM_LINES];
  assign line_repeat_select      = mframe_sync_config0[C0_LINE_REP];
  assign line_offset             = $signed(mframe_sync_config0[C0_OFFSET_LO +: 3]);
  assign line_nt_mode            = mframe_sync_config0[C0_NT_MODE_LO +: NUM_LINES];
  assign sync_sample_delay       = mframe_sync_config1[C1_DELAY_LO +: 4];
  assign frame_pulse_long        = pcm_mode_config0[PM_LONG];
  assign master_mode             = pcm_mode_config0[PM_MASTER];
  assign frame_len               = pcm_mode_config0[PM_LEN_LO +: POS_W];

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] pins_s;
  logic       bclk_s;
  logic       fp_s;
  logic       data_s;
  logic       pin_s;
  logic       int_s;

  pin_sync #(.W(5)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .async_in ({internal_mframe_sync_in, sync_in_pin, pcm_data_line_one,
                frame_pulse_in, bit_clock_io}),
    .sync_out (pins_s)
  );

  assign bclk_s = pins_s[0];
  assign fp_s   = pins_s[1];
  assign data_s = pins_s[2];
  assign pin_s  = pins_s[3];
  assign int_s  = pins_s[4];

  // ------------------------------------------------------------
  // Bit clock edge and frame position
  // ------------------------------------------------------------
  logic             bclk_d;
  logic             bclk_fall;
  logic             fp_at_fall;
  logic             frame_start;
  logic [POS_W-1:0] pos;
  logic [POS_W-1:0] next_pos;

  assign bclk_fall = bclk_d & ~bclk_s;

  // Slave frames align on the first falling edge that sees the pulse
  assign frame_start = bclk_fall &&
                       (master_mode ? (pos == frame_len - 10'h001)
                                    : (fp_s && !fp_at_fall));
  assign next_pos = frame_start ? '0 :
                    (&pos) ? pos : pos + 10'h001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_d <= 1'b0;
    end else if (ce) begin
      bclk_d <= bclk_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos        <= '0;
      fp_at_fall <= 1'b0;
    end else if (ce && bclk_fall) begin
      pos        <= next_pos;
      fp_at_fall <= fp_s;
    end
  end

  // ------------------------------------------------------------
  // Sync source selection and change detection
  // ------------------------------------------------------------
  logic src_sel;
  logic sample_point;
  logic last_sample;
  logic src_changed;
  logic window_open;
  logic resync;

  always_comb begin
    case (sync_source_select)
      SRC_FRAME_PULSE: src_sel = fp_s;
      SRC_SYNC_PIN:    src_sel = pin_s;
      SRC_PCM_DATA:    src_sel = data_s;
      SRC_INTERNAL:    src_sel = int_s;
      default:         src_sel = fp_s;
    endcase
  end

  // Position becomes delay+1 at this edge
  assign sample_point = bclk_fall && !frame_start &&
                        (pos == {6'h00, sync_sample_delay});
  assign src_changed  = src_sel != last_sample;
  assign resync = sync_detect_enable && window_open &&
                  sample_point && src_changed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_sample <= 1'b0;
    end else if (ce && sample_point) begin
      last_sample <= src_sel;
    end
  end

  // ------------------------------------------------------------
  // Frame counter and detection window
  // ------------------------------------------------------------
  logic [CNT_W-1:0] frame_cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] guard_val;
  logic             aligned;

  assign next_cnt  = (frame_cnt == CNT_LAST) ? '0 : frame_cnt + 6'h01;
  assign guard_val = resync_guard_select ? GUARD_SHORT : GUARD_LONG;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt <= '0;
    end else if (ce) begin
      if (resync) begin
        frame_cnt <= '0;
      end else if (frame_start) begin
        frame_cnt <= next_cnt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_open <= 1'b1;
    end else if (ce) begin
      if (resync) begin
        window_open <= 1'b0;
      end else if (frame_cnt == guard_val) begin
        window_open <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aligned <= 1'b0;
    end else if (ce && resync) begin
      aligned <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Frame pulse output shaping
  // ------------------------------------------------------------
  logic marker_frame;
  logic next_fp;

  assign marker_frame = mark_repeat_select ? (next_cnt[2:0] == 3'h0)
                                           : (next_cnt == '0);
  always_comb begin
    next_fp = (next_pos == frame_len - 10'h001);
    if (frame_pulse_long && next_pos == frame_len - 10'h002) begin
      next_fp = 1'b1;
    end
    if (frame_pulse_mark_enable && frame_start && marker_frame) begin
      next_fp = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_pulse_out <= 1'b0;
    end else if (ce && bclk_fall) begin
      frame_pulse_out <= next_fp;
    end
  end

  assign frame_pulse_oe = master_mode;

  // ------------------------------------------------------------
  // Line interface sync outputs
  // ------------------------------------------------------------
  logic [CNT_W-1:0] line_target;
  logic             line_hit;

  always_comb begin
    line_target = {{3{line_offset[2]}}, line_offset};
    if (line_offset < 0) begin
      line_target = (line_repeat_select ? PERIOD_SHORT : PERIOD_LONG)
                    + {{3{line_offset[2]}}, line_offset};
    end
  end
  assign line_hit = line_repeat_select ? (next_cnt[2:0] == line_target[2:0])
                                       : (next_cnt == line_target);

  genvar li;
  generate
    for (li = 0; li < NUM_LINES; li++) begin : g_line
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          line_mframe_sync_out[li] <= 1'b0;
        end else if (ce && frame_start) begin
          line_mframe_sync_out[li] <= line_sync_out_enable[li] &&
                                      line_nt_mode[li] && line_hit;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  logic apb_acc;
  logic addr_ok;

  assign apb_acc = psel && penable && ce;
  assign addr_ok = (paddr == OFS_CONFIG0) || (paddr == OFS_CONFIG1) ||
                   (paddr == OFS_PCM_MODE) || (paddr == OFS_STATUS);
  assign pready  = ce;
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mframe_sync_config0 <= C0_RESET;
      mframe_sync_config1 <= C1_RESET;
      pcm_mode_config0    <= PM_RESET;
    end else if (apb_acc && pwrite) begin
      case (paddr)
        OFS_CONFIG0:  mframe_sync_config0 <= pwdata[C0_WIDTH-1:0];
        OFS_CONFIG1:  mframe_sync_config1 <= pwdata[C1_WIDTH-1:0];
        OFS_PCM_MODE: pcm_mode_config0    <= pwdata[PM_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        OFS_CONFIG0:  prdata[C0_WIDTH-1:0] <= mframe_sync_config0;
        OFS_CONFIG1:  prdata[C1_WIDTH-1:0] <= mframe_sync_config1;
        OFS_PCM_MODE: prdata[PM_WIDTH-1:0] <= pcm_mode_config0;
        OFS_STATUS: begin
          prdata[ST_COUNT_LO +: CNT_W] <= frame_cnt;
          prdata[ST_WINDOW]            <= window_open;
          prdata[ST_ALIGNED]           <= aligned;
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_resync;
    ce && resync;
  endsequence

  sequence s_cleared;
    frame_cnt == '0 ##1 !window_open;
  endsequence

  cnt_range_a: assert property (frame_cnt <= CNT_LAST)
    else $error("frame counter above 39");

  cnt_step_a: assert property (ce && frame_start && !resync |=>
      frame_cnt == (($past(frame_cnt) == 6'h27) ? 6'h00 : $past(frame_cnt) + 6'h01))
    else $error("frame counter did not step");

  resync_zero_a: assert property (s_resync |=> s_cleared)
    else $error("resync did not clear counter and window");

  no_detect_a: assert property (!sync_detect_enable |-> !resync)
    else $error("resync while detection disabled");

  resync_cond_a: assert property (resync |-> window_open && sample_point && src_changed)
    else $error("resync without all conditions");

  window_guard_a: assert property (ce && !resync && !window_open &&
      frame_cnt == guard_val |=> window_open)
    else $error("window did not reopen at guard value");

  window_hold_a: assert property (ce && !window_open && frame_cnt != guard_val
      |=> !window_open)
    else $error("window reopened early");

  line_gate_a: assert property ($rose(line_mframe_sync_out[0]) |->
      $past(line_sync_out_enable[0]) && $past(line_nt_mode[0]))
    else $error("line sync without enable and NT mode");

  fp_norm_a: assert property (ce && bclk_fall && next_pos == frame_len - 10'h001
      |=> frame_pulse_out)
    else $error("frame pulse missing before frame start");

  fp_mark_a: assert property (ce && frame_start && frame_pulse_mark_enable &&
      !mark_repeat_select && next_cnt == 6'h00 && !resync |=> frame_pulse_out)
    else $error("marker extension missing");

  fp_early_a: assert property (ce && bclk_fall && frame_pulse_long &&
      next_pos == frame_len - 10'h002 |=> frame_pulse_out)
    else $error("early leading edge missing");

endmodule

/* File: design/pin_sync.sv */
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock, reset and enable
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage1[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else if (ce) begin
          stage1[i]   <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

/* File: pkg/mframe_sync_pkg.sv */
// Constants and types shared by the multiframe sync controller
package mframe_sync_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG0  = 8'h00;
  localparam logic [7:0] OFS_CONFIG1  = 8'h04;
  localparam logic [7:0] OFS_PCM_MODE = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;

  // ------------------------------------------------------------
  // mframe_sync_config0 fields
  // ------------------------------------------------------------
  localparam int C0_DETECT_EN  = 0;
  localparam int C0_SRC_LO     = 1;
  localparam int C0_GUARD      = 3;
  localparam int C0_MARK_EN    = 4;
  localparam int C0_MARK_REP   = 5;
  localparam int C0_LINE_EN_LO = 6;
  localparam int C0_LINE_REP   = 8;
  localparam int C0_OFFSET_LO  = 9;
  localparam int C0_NT_MODE_LO = 12;
  localparam int C0_WIDTH      = 14;
  localparam logic [C0_WIDTH-1:0] C0_RESET = 14'h0000;

  // ------------------------------------------------------------
  // mframe_sync_config1 and pcm_mode_config0 fields
  // ------------------------------------------------------------
  localparam int C1_DELAY_LO   = 0;
  localparam int C1_WIDTH      = 4;
  localparam logic [C1_WIDTH-1:0] C1_RESET = 4'h0;
  localparam int PM_LONG       = 0;
  localparam int PM_MASTER     = 1;
  localparam int PM_LEN_LO     = 4;
  localparam int PM_WIDTH      = 14;
  localparam logic [PM_WIDTH-1:0] PM_RESET = 14'h09c0;

  // ------------------------------------------------------------
  // Status fields
  // ------------------------------------------------------------
  localparam int ST_COUNT_LO   = 0;
  localparam int ST_WINDOW     = 8;
  localparam int ST_ALIGNED    = 9;

  // ------------------------------------------------------------
  // Counter and timing values
  // ------------------------------------------------------------
  localparam int CNT_W = 6;
  localparam int POS_W = 10;
  localparam int NUM_LINES = 2;
  localparam logic [CNT_W-1:0] CNT_LAST    = 6'h27;
  localparam logic [CNT_W-1:0] GUARD_LONG  = 6'h27;
  localparam logic [CNT_W-1:0] GUARD_SHORT = 6'h07;
  localparam logic [CNT_W-1:0] PERIOD_LONG = 6'h28;
  localparam logic [CNT_W-1:0] PERIOD_SHORT = 6'h08;

  typedef enum logic [1:0] {
    SRC_FRAME_PULSE,
    SRC_SYNC_PIN,
    SRC_PCM_DATA,
    SRC_INTERNAL
  } sync_src_t;

endpackage

/* File: test/pcm_bus_model.sv */
// Far-side PCM bus model: free-running bit clock and frame pulse
`timescale 1ns/10ps
module pcm_bus_model #(
  parameter int FRAME_LEN = 16
) (
  // PCM bus
  output logic bit_clock_io,
  output logic frame_pulse,
  output logic frame_start
);
  int pos = 0;

  // ----------------------------------------------------------
  // Bit clock, phase unrelated to pclk
  // ----------------------------------------------------------
  initial begin
    bit_clock_io = 1'b1;
    frame_pulse = 1'b0;
    frame_start = 1'b0;
    #137;
    forever #400 bit_clock_io = ~bit_clock_io;
  end

  // ----------------------------------------------------------
  // Frame pulse
  // ----------------------------------------------------------
  // High across the falling edge that opens a frame only
  always @(posedge bit_clock_io) frame_pulse <= (pos == FRAME_LEN - 1);
  always @(negedge bit_clock_io) begin
    frame_start <= (pos == FRAME_LEN - 1);
    pos <= (pos == FRAME_LEN - 1) ? 0 : pos + 1;
  end
endmodule

/* File: test/tb_mframe_sync_ctrl.sv */
// Self-checking bench for the multiframe sync controller
`timescale 1ns/10ps
module tb_mframe_sync_ctrl;
  import mframe_sync_pkg::*;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 fp_out;
  logic                 fp_oe;
  logic                 fp_far;
  logic                 fp_wire;
  logic                 bclk;
  logic                 fstart;
  logic                 sync_pin;
  logic                 int_sync;
  logic                 data_line;
  logic [NUM_LINES-1:0] line_out;
  logic [31:0]          rd;
  logic                 err;
  int                   mismatches;
  int                   checked;

  assign fp_wire = fp_oe ? fp_out : fp_far;
  always #50 pclk = ~pclk;

  mframe_sync_ctrl u_mframe_sync_ctrl (
    .pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_clock_io(bclk), .frame_pulse_in(fp_wire), .frame_pulse_out(fp_out),
    .frame_pulse_oe(fp_oe), .pcm_data_line_one(data_line), .sync_in_pin(sync_pin),
    .internal_mframe_sync_in(int_sync), .line_mframe_sync_out(line_out)
  );

  pcm_bus_model #(.FRAME_LEN(16)) u_pcm_bus_model (
    .bit_clock_io(bclk), .frame_pulse(fp_far), .frame_start(fstart)
  );

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Into the middle of the n-th next frame, past the sample point
  task automatic mid(input int n);
    repeat (n) @(posedge fstart);
    repeat (60) @(posedge pclk);
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, OFS_CONFIG0, 32'h0);
    chk("config0 reset", C0_RESET, rd);
    apb(1'b0, OFS_PCM_MODE, 32'h0);
    chk("pcm mode reset", PM_RESET, rd);
    chk("drive enable off", 32'h0, fp_oe);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, err);
    apb(1'b1, OFS_CONFIG1, 32'hffffffff);
    apb(1'b0, OFS_CONFIG1, 32'h0);
    chk("config1 width", 32'hf, rd);
    $display("t_reset done");
  endtask

  // Detection off: pin changes must not disturb the count
  task automatic t_free_run();
    logic [31:0] c1;
    apb(1'b1, OFS_PCM_MODE, 32'h100);
    apb(1'b1, OFS_CONFIG1, 32'h3);
    apb(1'b1, OFS_CONFIG0, 32'h02);
    mid(2);
    apb(1'b0, OFS_STATUS, 32'h0);
    c1 = rd & 32'h3f;
    repeat (3) begin
      sync_pin <= ~sync_pin;
      mid(15);
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("free count", (c1 + 45) % 40, rd & 32'h3f);
    $display("t_free_run done");
  endtask

  // Resync from pin, guard of 7, then from the internal input
  task automatic t_resync();
    int_sync <= 1'b1;
    apb(1'b1, OFS_CONFIG0, 32'h0b);
    mid(10);
    sync_pin <= ~sync_pin;
    mid(1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("resync status", 32'h200, rd & 32'h3ff);
    apb(1'b1, OFS_CONFIG0, 32'h0f);
    mid(1);
    int_sync <= 1'b0;
    mid(1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("guarded status", 32'h202, rd & 32'h3ff);
    mid(6);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("reopened status", 32'h308, rd & 32'h3ff);
    int_sync <= 1'b1;
    mid(1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("second resync", 32'h200, rd & 32'h3ff);
    apb(1'b1, OFS_CONFIG1, 32'h2);
    apb(1'b1, OFS_CONFIG0, 32'h0d);
    mid(8);
    data_line <= 1'b1;
    mid(1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("data line resync", 32'h200, rd & 32'h3ff);
    apb(1'b1, OFS_CONFIG0, 32'h0);
    $display("t_resync done");
  endtask

  // Master mode pulse widths over one full 40-frame period
  task automatic t_pulse(input logic lng, input logic mark, input logic rep);
    int w;
    int nfr;
    int nmk;
    int base;
    w = 0;
    nfr = 0;
    nmk = 0;
    base = lng ? 16 : 8;
    apb(1'b1, OFS_PCM_MODE, {31'h81, lng});
    apb(1'b1, OFS_CONFIG0, {26'h0, rep, mark, 4'h0});
    repeat (300) @(posedge pclk);
    chk("drive enable on", 32'h1, fp_oe);
    do @(posedge pclk); while (fp_out !== 1'b1);
    do @(posedge pclk); while (fp_out === 1'b1);
    repeat (5184) begin
      @(posedge pclk);
      if (fp_out === 1'b1) begin
        w++;
      end else if (w > 0) begin
        nfr++;
        if (w == base + 8 && mark) begin
          nmk++;
        end else begin
          chk("pulse width", base, w);
        end
        w = 0;
      end
    end
    chk("pulse count", 32'd40, nfr);
    chk("marked pulses", mark ? (rep ? 5 : 1) : 0, nmk);
    $display("t_pulse done %0d %0d %0d", lng, mark, rep);
  endtask

  // Line sync high cycles over one full 40-frame period
  task automatic t_line(input logic [31:0] cfg, input int e0, input int e1);
    int h0;
    int h1;
    h0 = 0;
    h1 = 0;
    apb(1'b1, OFS_CONFIG0, cfg);
    repeat (300) @(posedge pclk);
    repeat (5120) begin
      @(posedge pclk);
      h0 += (line_out[0] === 1'b1);
      h1 += (line_out[1] === 1'b1);
    end
    chk("line0 high", e0, h0);
    chk("line1 high", e1, h1);
    $display("t_line done %h", cfg);
  endtask

  // Line 0 sync must rise on the frame whose counter is the offset target
  task automatic t_offset(input logic [2:0] off, input logic [31:0] cnt);
    apb(1'b1, OFS_CONFIG0, 32'h10c0 | ({29'h0, off} << 9));
    @(posedge line_out[0]);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("line0 offset frame", cnt, rd & 32'h3f);
    $display("t_offset done %0d", cnt);
  endtask

  // ----------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sync_pin = 1'b0;
    int_sync = 1'b0;
    data_line = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_free_run();
    t_resync();
    t_pulse(1'b0, 1'b0, 1'b0);
    t_pulse(1'b1, 1'b0, 1'b0);
    t_pulse(1'b0, 1'b1, 1'b0);
    t_pulse(1'b1, 1'b1, 1'b1);
    t_line(32'h10c0, 128, 0);
    t_line(32'h3000, 0, 0);
    t_line(32'h31c0, 640, 640);
    t_offset(3'h7, 32'd39);
    t_offset(3'h3, 32'd3);
    print_verdict();
  end

  initial begin
    repeat (90000) @(posedge pclk);
    mismatches++;
    print_verdict();
  end
endmodule
